// >>> map_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "ram_map_defines.vh"
module map_chk #(parameter CTRL_NUMBER = 4'h0, parameter DATA_W = 16,
	parameter TEST_OFFS_W = `BLOCK_OFFS_W) (
	input wire logic                    clock,        // clock
	input wire logic                    reset,        // sync reset
	input wire logic                    bus_req,      // request
	input wire logic [`LOG_ADDR_W-1:0]  bus_addr,     // address
	input wire logic                    bus_ack,      // answer
	input wire logic                    bus_dbe,      // dbe pulse
	input wire logic [3:0]              err_ctrl_num, // ctrl number
	input wire logic [`PHYS_ADDR_W-1:0] err_loc,      // fail loc
	input wire logic                    test_done,    // test over
	input wire logic                    ram_we,       // ram write
	input wire logic [`PHYS_ADDR_W-1:0] ram_addr,     // ram addr
	input wire logic [DATA_W+5:0]       ram_wdata     // ram data
);
	localparam [17:0] TMASK = ~(((18'h00001 << `BLOCK_OFFS_W) - 18'h00001) &
		~((18'h00001 << TEST_OFFS_W) - 18'h00001));
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	chk_ack_cause: assert property (bus_ack |-> $past(bus_req, 2)
		&& $past(bus_addr[23:18], 2) == 6'h00) else $error("ack without hit request");
	chk_idle_in_test: assert property (!test_done |-> !bus_ack)
		else $error("ack during test");
	chk_test_start: assert property ($fell(reset) |-> ##[0:1] ram_we)
		else $error("test did not start");
	chk_pattern_val: assert property (!test_done && ram_we
		|-> ram_wdata == (ram_addr[0] ? `TEST_PATTERN_ALT : `TEST_PATTERN))
		else $error("wrong test pattern");
	chk_addr_step: assert property (!test_done && ram_we && $past(ram_we)
		|-> ram_addr == ((($past(ram_addr) | ~TMASK) + 18'h00001) & TMASK))
		else $error("write address skipped");
	chk_no_rewrite: assert property (!test_done && !$past(ram_we) && !$past(reset)
		|-> !ram_we || ram_addr == 0) else $error("write after read phase");
	chk_dbe_num: assert property (bus_dbe |-> err_ctrl_num == CTRL_NUMBER)
		else $error("wrong controller number");
	chk_loc_hold: assert property ($changed(err_loc) |-> bus_dbe)
		else $error("error location moved");
	cover property (bus_ack);
	cover property (bus_dbe && test_done);
	cover property ($rose(test_done));
endmodule // map_chk
`default_nettype wire

// >>> ram_block_map_self_test.v
// Summary of operation
// - 256 KB RAM split into 16 blocks of 16 KB, each one unit
// - each block placeable at any of the 16 lowest aligned logical block positions, or unmapped
// - a mapped-out block never answers any bus logical address
// - power-up test starts at once, never waits on other controllers
// - test patterns are written to all RAM bits, check bits included
// - write pattern across whole memory first, then read back block by block
// - block with read-back error or absent RAM is mapped out automatically
// - retested block with under 32 hard single-bit errors is healed and remapped
// - on double-bit error controller number and location are presented
// - single-bit errors corrected and held in 32 healer entries, no added delay
// - self-test injects a deliberate double-bit error for the CPU
`timescale 1ns/1ps
`default_nettype none
`include "ram_map_defines.vh"
module ram_block_map_self_test #(
	parameter CTRL_NUMBER = 4'h0, // controller number, arbitrary default
	parameter DATA_W      = 16,   // data word width
	parameter TEST_OFFS_W = `BLOCK_OFFS_W // offset bits walked per block by the power-up test
) (
	input  wire                     clock,        // 10 MHz clock
	input  wire                     reset,        // synchronous, active high
	input  wire                     clk_en,       // freezes all state when low
	input  wire                     bus_req,      // bus access request
	input  wire                     bus_we,       // write when high
	input  wire [`LOG_ADDR_W-1:0]   bus_addr,     // logical word address
	input  wire [DATA_W-1:0]        bus_wdata,    // write data
	output reg                      bus_ack,      // this controller answered
	output reg  [DATA_W-1:0]        bus_rdata,    // read data, corrected
	output reg                      bus_dbe,      // double-bit error pulse
	output reg  [3:0]               err_ctrl_num, // controller number on dbe
	output reg  [`PHYS_ADDR_W-1:0]  err_loc,      // failing physical location
	output reg                      healer_full,  // all healer entries used
	input  wire                     map_we,       // map entry write strobe
	input  wire [`BLOCK_IDX_W-1:0]  map_phys,     // physical block to set
	input  wire [`BLOCK_IDX_W-1:0]  map_log,      // logical block position
	input  wire                     map_valid,    // map in (1) or out (0)
	input  wire                     heal_clear,   // empty healer entries
	output reg                      test_done,    // power-up test finished
	output reg  [`NUM_BLOCKS-1:0]   suspect,      // blocks mapped out by test
	output reg                      ram_we,       // RAM write strobe
	output reg  [`PHYS_ADDR_W-1:0]  ram_addr,     // RAM address
	output reg  [DATA_W+5:0]        ram_wdata,    // data plus check bits
	input  wire [DATA_W+5:0]        ram_rdata,    // RAM read, valid next cycle
	input  wire                     ram_present,  // RAM fitted response
	input  wire                     ram_sbe,      // ecc single-bit error
	input  wire                     ram_dbe,      // ecc double-bit error
	input  wire [DATA_W-1:0]        ram_corr      // ecc corrected data
);
	localparam S_WRITE = 4'b0001;
	localparam S_READ  = 4'b0010;
	localparam S_INJ   = 4'b0100;
	localparam S_RUN   = 4'b1000;
	// offset bits above TEST_OFFS_W are skipped by the test walk; all bits by default
	localparam [`PHYS_ADDR_W-1:0] OFFS_ONES = (18'h00001 << `BLOCK_OFFS_W) - 18'h00001;
	localparam [`PHYS_ADDR_W-1:0] LOW_ONES  = (18'h00001 << TEST_OFFS_W) - 18'h00001;
	localparam [`PHYS_ADDR_W-1:0] TEST_MASK = ~(OFFS_ONES & ~LOW_ONES);
	reg [3:0]                  state_r;
	reg [`PHYS_ADDR_W-1:0]     cnt_r;
	reg                        rd_pend_r;
	reg [`BLOCK_IDX_W-1:0]     map_log_r [0:`NUM_BLOCKS-1];
	reg [`NUM_BLOCKS-1:0]      map_val_r;
	reg [`PHYS_ADDR_W-1:0]     heal_addr_r [0:`HEAL_ENTRIES-1];
	reg [DATA_W-1:0]           heal_data_r [0:`HEAL_ENTRIES-1];
	reg [`HEAL_ENTRIES-1:0]    heal_val_r;
	reg [`HEAL_IDX_W:0]        heal_cnt_r;
	reg [`PHYS_ADDR_W-1:0]     pend_addr_r;
	reg                        pend_r;
	reg                        pend_we_r;
	// logical to physical block match, one comparator per block
	wire [`NUM_BLOCKS-1:0]     hit;
	wire [`HEAL_ENTRIES-1:0]   heal_hit;
	genvar g;
	generate
		for (g = 0; g < `NUM_BLOCKS; g = g + 1)
		begin : g_map
			assign hit[g] = map_val_r[g] &&
				(bus_addr[`LOG_ADDR_W-1:`BLOCK_OFFS_W] ==
				{{(`LOG_ADDR_W-`BLOCK_OFFS_W-`BLOCK_IDX_W){1'b0}}, map_log_r[g]});
		end
		for (g = 0; g < `HEAL_ENTRIES; g = g + 1)
		begin : g_heal
			assign heal_hit[g] = heal_val_r[g] && (heal_addr_r[g] == pend_addr_r);
		end
	endgenerate
	reg [`BLOCK_IDX_W-1:0] hit_blk;
	reg                    any_hit;
	reg [DATA_W-1:0]       heal_dat;
	reg                    heal_any;
	integer i;
	always @*
	begin
		hit_blk = {`BLOCK_IDX_W{1'b0}};
		any_hit = 1'b0;
		heal_dat = {DATA_W{1'b0}};
		heal_any = 1'b0;
		for (i = 0; i < `NUM_BLOCKS; i = i + 1)
			if (hit[i])
			begin
				hit_blk = i[`BLOCK_IDX_W-1:0];
				any_hit = 1'b1;
			end
		for (i = 0; i < `HEAL_ENTRIES; i = i + 1)
			if (heal_hit[i])
			begin
				heal_dat = heal_data_r[i];
				heal_any = 1'b1;
			end
	end
	// block of the word whose read-back is judged this cycle
	wire [`BLOCK_IDX_W-1:0] cur_blk = ram_addr[`PHYS_ADDR_W-1:`BLOCK_OFFS_W];
	wire [DATA_W+5:0] pat = cnt_r[0] ? `TEST_PATTERN_ALT : `TEST_PATTERN;
	// skipped offset bits are forced high so the carry jumps over them
	wire [`PHYS_ADDR_W-1:0] cnt_step = ((cnt_r | ~TEST_MASK) + 18'h00001) & TEST_MASK;
	wire              last = (cnt_r == TEST_MASK);
	wire              heal_store = pend_r && !pend_we_r && !heal_any && ram_sbe && !ram_dbe &&
		(heal_clear || heal_cnt_r < `HEAL_LIMIT);
	wire [`HEAL_IDX_W-1:0] heal_idx = heal_clear ? {`HEAL_IDX_W{1'b0}} :
		heal_cnt_r[`HEAL_IDX_W-1:0];
	always @(posedge clock)
	begin
		if (reset)
		begin
			state_r <= S_WRITE;
			cnt_r <= {`PHYS_ADDR_W{1'b0}};
			rd_pend_r <= 1'b0;
			map_val_r <= {`NUM_BLOCKS{1'b1}};
			heal_val_r <= {`HEAL_ENTRIES{1'b0}};
			heal_cnt_r <= 6'h00;
			pend_r <= 1'b0;
			pend_we_r <= 1'b0;
			pend_addr_r <= {`PHYS_ADDR_W{1'b0}};
			bus_ack <= 1'b0;
			bus_rdata <= {DATA_W{1'b0}};
			bus_dbe <= 1'b0;
			err_ctrl_num <= 4'h0;
			err_loc <= {`PHYS_ADDR_W{1'b0}};
			healer_full <= 1'b0;
			test_done <= 1'b0;
			suspect <= {`NUM_BLOCKS{1'b0}};
			ram_we <= 1'b0;
			ram_addr <= {`PHYS_ADDR_W{1'b0}};
			ram_wdata <= {(DATA_W+6){1'b0}};
			for (i = 0; i < `NUM_BLOCKS; i = i + 1)
				map_log_r[i] <= i[`BLOCK_IDX_W-1:0];
		end
		else if (clk_en)
		begin
			bus_ack <= 1'b0;
			bus_dbe <= 1'b0;
			ram_we <= 1'b0;
			case (state_r)
			S_WRITE:
			begin
				ram_we <= 1'b1;
				ram_addr <= cnt_r;
				ram_wdata <= pat;
				cnt_r <= cnt_step;
				if (last)
					state_r <= S_READ;
			end
			S_READ:
			begin
				ram_addr <= cnt_r;
				rd_pend_r <= 1'b1;
				if (rd_pend_r && (!ram_present || ram_rdata !=
					(ram_addr[0] ? `TEST_PATTERN_ALT : `TEST_PATTERN)))
				begin
					map_val_r[cur_blk] <= 1'b0;
					suspect[cur_blk] <= 1'b1;
				end
				if (rd_pend_r && ram_addr == TEST_MASK)
					state_r <= S_INJ;
				else if (!last)
					cnt_r <= cnt_step;
			end
			S_INJ:
			begin
				bus_dbe <= 1'b1;
				err_ctrl_num <= CTRL_NUMBER;
				err_loc <= `DBE_INJECT_ADDR;
				test_done <= 1'b1;
				rd_pend_r <= 1'b0;
				state_r <= S_RUN;
			end
			S_RUN:
			begin
				if (map_we)
				begin
					map_log_r[map_phys] <= map_log;
					map_val_r[map_phys] <= map_valid;
					if (map_valid)
						suspect[map_phys] <= 1'b0;
				end
				// no new take while the answer stands: the master is still releasing
				if (bus_req && any_hit && !pend_r && !bus_ack)
				begin
					pend_r <= 1'b1;
					pend_we_r <= bus_we;
					pend_addr_r <= {hit_blk, bus_addr[`BLOCK_OFFS_W-1:0]};
					ram_addr <= {hit_blk, bus_addr[`BLOCK_OFFS_W-1:0]};
					ram_we <= bus_we;
					ram_wdata <= {6'h00, bus_wdata};
				end
				if (pend_r)
				begin
					pend_r <= 1'b0;
					bus_ack <= 1'b1;
					if (!pend_we_r)
					begin
						if (heal_any)
							bus_rdata <= heal_dat;
						else if (ram_dbe)
						begin
							bus_dbe <= 1'b1;
							err_ctrl_num <= CTRL_NUMBER;
							err_loc <= pend_addr_r;
							bus_rdata <= ram_rdata[DATA_W-1:0];
						end
						else
							bus_rdata <= ram_sbe ? ram_corr : ram_rdata[DATA_W-1:0];
					end
				end
				healer_full <= (heal_cnt_r == `HEAL_LIMIT);
				// a clear in the cycle of a new entry keeps that entry, in slot 0
				if (heal_clear)
				begin
					heal_val_r <= {`HEAL_ENTRIES{1'b0}};
					heal_cnt_r <= {{`HEAL_IDX_W{1'b0}}, heal_store};
				end
				if (heal_store)
				begin
					heal_val_r[heal_idx] <= 1'b1;
					heal_addr_r[heal_idx] <= pend_addr_r;
					heal_data_r[heal_idx] <= ram_corr;
					if (!heal_clear)
						heal_cnt_r <= heal_cnt_r + 1'b1;
				end
			end
			default:
				state_r <= S_WRITE;
			endcase
		end
	end
endmodule // ram_block_map_self_test
`default_nettype wire

// >>> ram_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module ram_far_model (
	input  wire logic        clock,    // clock
	input  wire logic        we,       // write
	input  wire logic [17:0] addr,     // address
	input  wire logic [21:0] wdata,    // data in
	input  wire logic [3:0]  bad_blk,  // faulty block
	input  wire logic [3:0]  gone_blk, // unfitted block
	input  wire logic [1:0]  mode,     // 1 sbe, 2 dbe, 3 quiet flip
	output logic      [21:0] rdata,    // data out
	output logic             present,  // fitted
	output logic             sbe,      // single error
	output logic             dbe,      // double error
	output logic      [15:0] corr      // corrected
);
	logic [21:0] mem [0:262143];
	always @(posedge clock)
		if (we)
			mem[addr] <= wdata;
	// read answer follows the address within the cycle, ready at the next edge
	assign present = addr[17:14] != gone_blk;
	assign rdata = (addr[17:14] == gone_blk) ? ~mem[addr]
		: mem[addr] ^ {21'h0, addr[17:14] == bad_blk || mode[0]};
	assign sbe = mode == 2'h1;
	assign dbe = mode == 2'h2;
	assign corr = mem[addr][15:0];
endmodule // ram_far_model
`default_nettype wire

// >>> ram_map_defines.vh
`ifndef RAM_MAP_DEFINES_VH
`define RAM_MAP_DEFINES_VH
`define NUM_BLOCKS       16
`define BLOCK_IDX_W      4
`define BLOCK_OFFS_W     14
`define PHYS_ADDR_W      18
`define LOG_ADDR_W       24
`define HEAL_ENTRIES     32
`define HEAL_IDX_W       5
`define HEAL_LIMIT       6'h20
`define TEST_PATTERN     22'h2AAAAA
`define TEST_PATTERN_ALT 22'h155555
`define DBE_INJECT_ADDR  18'h00000
`endif

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clock, reset, bus_req, bus_we, map_we, map_valid, dbe_at, heal_clear;
	logic [23:0] bus_addr;
	logic [15:0] bus_wdata, rd;
	logic [3:0]  map_phys, map_log, bad_blk;
	logic [1:0]  mode;
	wire         bus_ack, bus_dbe, test_done, ram_we, ram_present, ram_sbe, ram_dbe, healer_full;
	wire  [15:0] bus_rdata, ram_corr, suspect;
	wire  [3:0]  err_ctrl_num;
	wire  [17:0] err_loc, ram_addr;
	wire  [21:0] ram_wdata, ram_rdata;
	int          errors = 0, n_checks = 0, dbe_n = 0;
	ram_block_map_self_test #(.CTRL_NUMBER(4'h5), .TEST_OFFS_W(2)) ram_block_map_self_test_i (
		.clock, .reset, .clk_en(1'b1), .bus_req, .bus_we, .bus_addr, .bus_wdata, .bus_ack,
		.bus_rdata, .bus_dbe, .err_ctrl_num, .err_loc, .healer_full, .map_we, .map_phys,
		.map_log, .map_valid, .heal_clear, .test_done, .suspect, .ram_we, .ram_addr,
		.ram_wdata, .ram_rdata, .ram_present, .ram_sbe, .ram_dbe, .ram_corr);
	ram_far_model ram_far_model_i (.clock, .we(ram_we), .addr(ram_addr), .wdata(ram_wdata),
		.bad_blk, .gone_blk(4'hB), .mode, .rdata(ram_rdata), .present(ram_present),
		.sbe(ram_sbe), .dbe(ram_dbe), .corr(ram_corr));
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock)
		if (bus_dbe === 1'b1)
			dbe_n++;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic bus(input logic we, input logic [23:0] a, input logic [15:0] d, input int e);
		int n;
		n = 0;
		@(posedge clock);
		{bus_req, bus_we, bus_addr, bus_wdata} <= {1'b1, we, a, d};
		do
		begin
			@(posedge clock);
			n++;
		end
		while (bus_ack !== 1'b1 && n < 6);
		bus_req <= 1'b0;
		rd = bus_rdata;
		dbe_at = bus_dbe;
		chk(n, e);
		repeat (3) @(posedge clock);
	endtask
	task automatic mapw(input logic [3:0] p, input logic [3:0] l, input logic v);
		@(posedge clock);
		{map_we, map_phys, map_log, map_valid} <= {1'b1, p, l, v};
		@(posedge clock);
		map_we <= 1'b0;
	endtask
	task automatic t_selftest;
		for (int i = 0; i < 2000 && test_done !== 1'b1; i++)
			@(posedge clock);
		repeat (4) @(posedge clock);
		chk(test_done, 1'b1);
		chk(suspect, 16'h0A00);
		chk(dbe_n, 1);
		chk({err_ctrl_num, err_loc}, {4'h5, 18'h00000});
		$display("selftest done");
	endtask
	task automatic t_map;
		bus(1'b1, 24'h004010, 16'h1234, 3);
		mapw(4'h1, 4'h7, 1'b1);
		mapw(4'h7, 4'h7, 1'b0);
		bus(1'b0, 24'h01C010, 16'h0000, 3);
		chk(rd, 16'h1234);
		bus(1'b0, 24'h004010, 16'h0000, 6);
		bus(1'b0, 24'h41C010, 16'h0000, 6);
		mapw(4'h2, 4'h2, 1'b0);
		bus(1'b0, 24'h008000, 16'h0000, 6);
		$display("map done");
	endtask
	task automatic t_retest;
		bus(1'b0, 24'h024000, 16'h0000, 6);
		bus(1'b0, 24'h02C000, 16'h0000, 6);
		bad_blk <= 4'hF;
		mapw(4'h9, 4'h9, 1'b1);
		bus(1'b1, 24'h024005, 16'h5A5A, 3);
		bus(1'b0, 24'h024005, 16'h0000, 3);
		chk(rd, 16'h5A5A);
		chk(suspect, 16'h0800);
		$display("retest done");
	endtask
	task automatic t_errs;
		mode <= 2'h2;
		bus(1'b0, 24'h000020, 16'h0000, 3);
		chk({dbe_at, err_ctrl_num, err_loc}, {1'b1, 4'h5, 18'h00020});
		mode <= 2'h0;
		bus(1'b1, 24'h000030, 16'hBEEF, 3);
		mode <= 2'h1;
		bus(1'b0, 24'h000030, 16'h0000, 3);
		chk(rd, 16'hBEEF);
		mode <= 2'h3;
		bus(1'b0, 24'h000030, 16'h0000, 3);
		chk(rd, 16'hBEEF);
		chk(healer_full, 1'b0);
		mode <= 2'h1;
		for (int i = 0; i < 31; i++)
			bus(1'b0, 24'h000040 + i, 16'h0000, 3);
		chk(healer_full, 1'b1);
		heal_clear <= 1'b1;
		@(posedge clock);
		heal_clear <= 1'b0;
		repeat (2) @(posedge clock);
		chk(healer_full, 1'b0);
		mode <= 2'h3;
		bus(1'b0, 24'h000030, 16'h0000, 3);
		chk(rd, 16'hBEEE);
		mode <= 2'h0;
		$display("errors done");
	endtask
	initial
	begin
		{bus_req, bus_we, bus_addr, bus_wdata} = '0;
		{map_we, map_phys, map_log, map_valid, heal_clear} = '0;
		{bad_blk, mode} = {4'h9, 2'h0};
		reset = 1'b1;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		t_selftest;
		t_map;
		t_retest;
		t_errs;
		give_verdict;
	end
	initial
	begin
		repeat (5000) @(posedge clock);
		errors++;
		give_verdict;
	end
endmodule // tb
bind ram_block_map_self_test map_chk #(.CTRL_NUMBER(CTRL_NUMBER), .DATA_W(DATA_W),
	.TEST_OFFS_W(TEST_OFFS_W)) map_chk_i (
	.clock, .reset, .bus_req, .bus_addr, .bus_ack, .bus_dbe, .err_ctrl_num, .err_loc,
	.test_done, .ram_we, .ram_addr, .ram_wdata);
`default_nettype wire
